// ### shared/fpcf_pkg.sv
package fpcf_pkg;
   localparam int NPART = 8;
   localparam int PART_W = 3;
   localparam int BLK_W = 8;
   localparam int DATA_W = 16;

   localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_READ_ID = 8'h90;
   localparam logic [7:0] CMD_READ_QUERY = 8'h98;
   localparam logic [7:0] CMD_CLR_STATUS = 8'h50;
   localparam logic [7:0] CMD_PGM_SETUP = 8'h40;
   localparam logic [7:0] CMD_PGM_SETUP_ALT = 8'h10;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
   localparam logic [7:0] CMD_CONFIRM = 8'hD0;
   localparam logic [7:0] CMD_SUSPEND = 8'hB0;
   localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
   localparam logic [7:0] CMD_OTP_SETUP = 8'hC0;
   localparam logic [7:0] CMD_FFP_SETUP = 8'h30;
   localparam logic [7:0] CMD_LOCK_CONF = 8'h01;
   localparam logic [7:0] CMD_LOCKDN_CONF = 8'h2F;
   localparam logic [7:0] CMD_CFG_CONF = 8'h03;

   typedef enum logic [1:0] {MODE_ARRAY, MODE_ID, MODE_STATUS} fpcf_mode_t;

   typedef enum logic [4:0] {
      ST_READY, ST_PGM_SETUP, ST_PGM_BUSY, ST_PGM_SUSP,
      ST_ERS_SETUP, ST_ERS_BUSY, ST_ERS_SUSP,
      ST_PES_SETUP, ST_PES_BUSY, ST_PES_SUSP,
      ST_LCK_SETUP, ST_LCK_SETUP_ES, ST_OTP_SETUP, ST_OTP_BUSY,
      ST_FFP_SETUP, ST_FFP_BUSY, ST_FFP_VERIFY
   } fpcf_state_t;

   typedef enum logic [3:0] {
      OP_NONE, OP_PGM, OP_ERASE, OP_OTP, OP_LOCK, OP_UNLOCK, OP_LOCKDN,
      OP_CFG, OP_FFP_WORD, OP_SUSPEND, OP_RESUME, OP_CLR_STAT
   } fpcf_op_t;

   typedef struct packed {
      logic [PART_W-1:0] part;
      logic [BLK_W-1:0] blk;
      logic [DATA_W-1:0] data;
   } fpcf_wr_t;

   localparam fpcf_mode_t MODE_RESET = MODE_ARRAY;
   localparam fpcf_state_t STATE_RESET = ST_READY;
   localparam logic [PART_W-1:0] PART_RESET = 3'h0;
   localparam logic [BLK_W-1:0] BLK_RESET = 8'h00;
endpackage

// ### hdl/fpcf_part_modes.sv
`timescale 1ns/1ps
`default_nettype none
module fpcf_part_modes (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic mode_we_i,
   input wire logic [fpcf_pkg::PART_W-1:0] mode_part_i,
   input wire fpcf_pkg::fpcf_mode_t mode_i,
   input wire logic [fpcf_pkg::PART_W-1:0] rd_part_i,
   output fpcf_pkg::fpcf_mode_t rd_mode_o
);
   import fpcf_pkg::*;

   fpcf_mode_t mode_ff [NPART];
   fpcf_mode_t rd_mode_ff;

   // Per-partition mode store
   always_ff @(posedge sys_clk_i) begin
      for (int i = 0; i < NPART; i++) begin
         if (!reset_n_i) begin
            mode_ff[i] <= MODE_RESET;
         end else if (mode_we_i && mode_part_i == PART_W'(i)) begin
            mode_ff[i] <= mode_i;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         rd_mode_ff <= MODE_RESET;
      end else begin
         rd_mode_ff <= mode_ff[rd_part_i];
      end
   end

   assign rd_mode_o = rd_mode_ff;

   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);

   property p_mode_hold;
      !mode_we_i |=> mode_ff[$past(rd_part_i)] == $past(mode_ff[rd_part_i]);
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("mode changed without command");

   property p_mode_target;
      mode_we_i |=> mode_ff[$past(mode_part_i)] == $past(mode_i);
   endproperty
   a_mode_target: assert property (p_mode_target) else $error("mode not set on target");

   property p_reset_array;
      @(posedge sys_clk_i) $rose(reset_n_i) |-> mode_ff[rd_part_i] == MODE_ARRAY;
   endproperty
   a_reset_array: assert property (p_reset_array) else $error("not array after reset");
endmodule
`default_nettype wire

// ### hdl/fpcf_cmd_fsm.sv
`timescale 1ns/1ps
`default_nettype none
module fpcf_cmd_fsm (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic wr_en_i,
   input wire fpcf_pkg::fpcf_wr_t wr_i,
   input wire logic op_done_i,
   input wire logic ffp_word_busy_i,
   input wire logic [fpcf_pkg::PART_W-1:0] rd_part_i,
   output fpcf_pkg::fpcf_state_t state_o,
   output fpcf_pkg::fpcf_op_t op_o,
   output fpcf_pkg::fpcf_wr_t op_wr_o,
   output fpcf_pkg::fpcf_mode_t rd_mode_o,
   output logic rd_undefined_o,
   output logic seq_err_o,
   output logic lock_err_o,
   output logic factory_write_ready_bit_o
);
   import fpcf_pkg::*;

   function automatic logic is_running(fpcf_state_t s);
      return s inside {ST_PGM_BUSY, ST_ERS_BUSY, ST_PES_BUSY, ST_OTP_BUSY,
                       ST_FFP_SETUP, ST_FFP_BUSY, ST_FFP_VERIFY};
   endfunction

   function automatic logic is_suspended(fpcf_state_t s);
      return s inside {ST_PGM_SUSP, ST_ERS_SUSP, ST_PES_SUSP};
   endfunction

   function automatic fpcf_op_t lock_op(logic [7:0] c);
      case (c)
         CMD_LOCK_CONF: return OP_LOCK;
         CMD_CONFIRM: return OP_UNLOCK;
         CMD_LOCKDN_CONF: return OP_LOCKDN;
         CMD_CFG_CONF: return OP_CFG;
         default: return OP_NONE;
      endcase
   endfunction

   fpcf_state_t state_ff, nxt_state;
   fpcf_op_t op_ff, nxt_op;
   fpcf_wr_t op_wr_ff;
   logic [BLK_W-1:0] ffp_blk_ff;
   logic [PART_W-1:0] busy_part_ff;
   logic seq_err_ff, lock_err_ff, rd_undef_ff;
   logic set_seq, set_lock, data_cycle, start_op;

   wire logic [7:0] cmd = wr_i.data[7:0];
   wire logic cmd_pgm = cmd == CMD_PGM_SETUP || cmd == CMD_PGM_SETUP_ALT;
   wire logic cmd_suspend = wr_en_i && cmd == CMD_SUSPEND;
   wire logic cmd_resume = wr_en_i && cmd == CMD_CONFIRM;
   wire logic ffp_same_blk = wr_i.blk == ffp_blk_ff;
   wire logic clr_ok = !is_running(state_ff) && !is_suspended(state_ff);
   wire logic clr_status = wr_en_i && state_ff == ST_READY && cmd == CMD_CLR_STATUS && clr_ok;
   wire logic cmd_known = cmd inside {CMD_READ_ARRAY, CMD_READ_STATUS, CMD_READ_ID,
      CMD_READ_QUERY, CMD_CLR_STATUS, CMD_PGM_SETUP, CMD_PGM_SETUP_ALT, CMD_ERASE_SETUP,
      CMD_CONFIRM, CMD_SUSPEND, CMD_LOCK_SETUP, CMD_OTP_SETUP, CMD_FFP_SETUP,
      CMD_LOCK_CONF, CMD_LOCKDN_CONF, CMD_CFG_CONF};
   wire logic illegal_cmd = wr_en_i && !cmd_known;

   // Engine next state from engine state, the write, op_done_i and the latched factory block
   always_comb begin
      nxt_state = state_ff;
      nxt_op = OP_NONE;
      set_seq = 1'b0;
      set_lock = 1'b0;
      data_cycle = 1'b0;
      start_op = 1'b0;
      case (state_ff)
         ST_READY: begin
            if (wr_en_i) begin
               if (cmd_pgm) nxt_state = ST_PGM_SETUP;
               else if (cmd == CMD_ERASE_SETUP) nxt_state = ST_ERS_SETUP;
               else if (cmd == CMD_LOCK_SETUP) nxt_state = ST_LCK_SETUP;
               else if (cmd == CMD_OTP_SETUP) nxt_state = ST_OTP_SETUP;
               else if (cmd == CMD_FFP_SETUP) nxt_state = ST_FFP_SETUP;
               else if (clr_status) nxt_op = OP_CLR_STAT;
               else if (illegal_cmd) set_seq = 1'b1;
            end
         end
         ST_PGM_SETUP: begin
            if (wr_en_i) begin
               nxt_state = ST_PGM_BUSY;
               nxt_op = OP_PGM;
               data_cycle = 1'b1;
               start_op = 1'b1;
            end
         end
         ST_PGM_BUSY, ST_ERS_BUSY, ST_PES_BUSY: begin
            if (op_done_i) begin
               nxt_state = state_ff == ST_PES_BUSY ? ST_ERS_SUSP : ST_READY;
            end else if (cmd_suspend) begin
               nxt_op = OP_SUSPEND;
               nxt_state = state_ff == ST_PGM_BUSY ? ST_PGM_SUSP :
                           state_ff == ST_ERS_BUSY ? ST_ERS_SUSP : ST_PES_SUSP;
            end
         end
         ST_PGM_SUSP, ST_PES_SUSP: begin
            if (cmd_resume) begin
               nxt_op = OP_RESUME;
               nxt_state = state_ff == ST_PGM_SUSP ? ST_PGM_BUSY : ST_PES_BUSY;
            end
         end
         ST_ERS_SETUP: begin
            if (wr_en_i) begin
               start_op = cmd == CMD_CONFIRM;
               nxt_state = start_op ? ST_ERS_BUSY : ST_READY;
               nxt_op = start_op ? OP_ERASE : OP_NONE;
               set_seq = !start_op;
            end
         end
         ST_ERS_SUSP: begin
            if (wr_en_i) begin
               if (cmd_pgm) nxt_state = ST_PES_SETUP;
               else if (cmd == CMD_LOCK_SETUP) nxt_state = ST_LCK_SETUP_ES;
               else if (cmd == CMD_CONFIRM) begin
                  nxt_state = ST_ERS_BUSY;
                  nxt_op = OP_RESUME;
               end
            end
         end
         ST_PES_SETUP: begin
            if (wr_en_i) begin
               nxt_state = ST_PES_BUSY;
               nxt_op = OP_PGM;
               data_cycle = 1'b1;
               start_op = 1'b1;
            end
         end
         ST_LCK_SETUP, ST_LCK_SETUP_ES: begin
            if (wr_en_i) begin
               nxt_state = state_ff == ST_LCK_SETUP ? ST_READY : ST_ERS_SUSP;
               nxt_op = lock_op(cmd);
               set_lock = lock_op(cmd) == OP_NONE;
            end
         end
         ST_OTP_SETUP: begin
            if (wr_en_i) begin
               nxt_state = ST_OTP_BUSY;
               nxt_op = OP_OTP;
               data_cycle = 1'b1;
               start_op = 1'b1;
            end
         end
         ST_OTP_BUSY: begin
            if (op_done_i) nxt_state = ST_READY;
         end
         ST_FFP_SETUP: begin
            if (wr_en_i) begin
               nxt_state = cmd == CMD_CONFIRM ? ST_FFP_BUSY : ST_READY;
               set_seq = cmd != CMD_CONFIRM;
               start_op = cmd == CMD_CONFIRM;
            end
         end
         ST_FFP_BUSY, ST_FFP_VERIFY: begin
            if (wr_en_i && ffp_same_blk) begin
               data_cycle = 1'b1;
               nxt_op = OP_FFP_WORD;
            end else if (wr_en_i) begin
               nxt_state = state_ff == ST_FFP_BUSY ? ST_FFP_VERIFY : ST_READY;
            end else if (op_done_i && state_ff == ST_FFP_VERIFY) begin
               nxt_state = ST_READY;
            end
         end
         default: nxt_state = ST_READY;
      endcase
   end

   // Mode decode; a second or data cycle puts its own partition in status
   wire logic mode_status = cmd inside {CMD_READ_STATUS, CMD_PGM_SETUP, CMD_PGM_SETUP_ALT,
      CMD_ERASE_SETUP, CMD_CONFIRM, CMD_SUSPEND, CMD_LOCK_SETUP, CMD_OTP_SETUP,
      CMD_FFP_SETUP, CMD_LOCK_CONF, CMD_LOCKDN_CONF, CMD_CFG_CONF};
   wire logic mode_id = cmd == CMD_READ_ID || cmd == CMD_READ_QUERY;
   wire logic mode_hit = mode_status || mode_id || cmd == CMD_READ_ARRAY;
   wire logic mode_we = wr_en_i && (data_cycle || mode_hit);
   wire fpcf_mode_t mode_val = data_cycle || mode_status ? MODE_STATUS :
      mode_id ? MODE_ID : MODE_ARRAY;

   fpcf_part_modes fpcf_part_modes_i (
      .sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i),
      .mode_we_i(mode_we),
      .mode_part_i(wr_i.part),
      .mode_i(mode_val),
      .rd_part_i(rd_part_i),
      .rd_mode_o(rd_mode_o)
   );

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         state_ff <= STATE_RESET;
         op_ff <= OP_NONE;
         op_wr_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         op_ff <= nxt_op;
         op_wr_ff <= nxt_op != OP_NONE ? wr_i : op_wr_ff;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         ffp_blk_ff <= BLK_RESET;
         busy_part_ff <= PART_RESET;
         rd_undef_ff <= 1'b0;
      end else begin
         ffp_blk_ff <= state_ff == ST_FFP_SETUP && start_op ? wr_i.blk : ffp_blk_ff;
         busy_part_ff <= start_op ? wr_i.part : busy_part_ff;
         rd_undef_ff <= is_running(state_ff) && rd_part_i == busy_part_ff;
      end
   end

   // Error bits: a new error wins over a clear in the same cycle
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         seq_err_ff <= 1'b0;
         lock_err_ff <= 1'b0;
      end else begin
         seq_err_ff <= set_seq | (seq_err_ff & !clr_status);
         lock_err_ff <= set_lock | (lock_err_ff & !clr_status);
      end
   end

   assign state_o = state_ff;
   assign op_o = op_ff;
   assign op_wr_o = op_wr_ff;
   assign rd_undefined_o = rd_undef_ff && rd_mode_o == MODE_ARRAY;
   assign seq_err_o = seq_err_ff;
   assign lock_err_o = lock_err_ff;
   // Low only in ST_FFP_BUSY while ffp_word_busy_i is low; high in ST_FFP_VERIFY, which still takes same-block words
   assign factory_write_ready_bit_o = !(state_ff == ST_FFP_BUSY && !ffp_word_busy_i);

   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);

   property p_done_ready;
      state_ff inside {ST_PGM_BUSY, ST_ERS_BUSY, ST_OTP_BUSY} && op_done_i
         |=> state_ff == ST_READY;
   endproperty
   a_done_ready: assert property (p_done_ready) else $error("done did not return to ready");

   property p_pes_done;
      state_ff == ST_PES_BUSY && op_done_i |=> state_ff == ST_ERS_SUSP;
   endproperty
   a_pes_done: assert property (p_pes_done) else $error("nested program lost suspend");

   property p_busy_ignore;
      state_ff == ST_ERS_BUSY && wr_en_i && !op_done_i && cmd != CMD_SUSPEND
         |=> state_ff == ST_ERS_BUSY && op_ff == OP_NONE;
   endproperty
   a_busy_ignore: assert property (p_busy_ignore) else $error("command taken while busy");

   property p_clr_idle;
      op_ff == OP_CLR_STAT |-> $past(state_ff) == ST_READY && !seq_err_ff && !lock_err_ff;
   endproperty
   a_clr_idle: assert property (p_clr_idle) else $error("clear status misbehaved");

   sequence s_lock_conf;
      state_ff == ST_LCK_SETUP && wr_en_i && cmd == CMD_LOCK_CONF;
   endsequence
   property p_lock_conf;
      s_lock_conf |=> state_ff == ST_READY && op_ff == OP_LOCK ##1 op_ff != OP_LOCK;
   endproperty
   a_lock_conf: assert property (p_lock_conf) else $error("lock confirm not executed");

   property p_es_ignore;
      state_ff == ST_ERS_SUSP && wr_en_i &&
         (cmd == CMD_OTP_SETUP || cmd == CMD_FFP_SETUP || cmd == CMD_ERASE_SETUP)
         |=> state_ff == ST_ERS_SUSP;
   endproperty
   a_es_ignore: assert property (p_es_ignore) else $error("bad command in erase suspend");

   property p_ps_ignore;
      state_ff inside {ST_PGM_SUSP, ST_PES_SUSP} && wr_en_i && cmd != CMD_CONFIRM
         |=> state_ff == $past(state_ff) && op_ff == OP_NONE;
   endproperty
   a_ps_ignore: assert property (p_ps_ignore) else $error("command ran in program suspend");

   sequence s_ffp_other;
      state_ff == ST_FFP_BUSY && wr_en_i && !ffp_same_blk;
   endsequence
   property p_ffp_exit;
      s_ffp_other |=> state_ff == ST_FFP_VERIFY;
   endproperty
   a_ffp_exit: assert property (p_ffp_exit) else $error("factory program did not verify");

   property p_ffp_data;
      state_ff == ST_FFP_BUSY && wr_en_i && ffp_same_blk |=> op_ff == OP_FFP_WORD
         && state_ff == ST_FFP_BUSY;
   endproperty
   a_ffp_data: assert property (p_ffp_data) else $error("factory data word lost");

   property p_illegal;
      state_ff == ST_READY && illegal_cmd |=> seq_err_o ##1 (seq_err_o || op_ff == OP_CLR_STAT);
   endproperty
   a_illegal: assert property (p_illegal) else $error("illegal command not flagged");
endmodule
`default_nettype wire

// ### dv/fpcf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fpcf_host_model (
   input wire logic sys_clk_i,
   input wire logic factory_write_ready_bit_i,
   output logic wr_en_o,
   output fpcf_pkg::fpcf_wr_t wr_o
);
   import fpcf_pkg::*;
   initial begin
      wr_en_o = 1'b0;
      wr_o = '0;
   end
   // One write cycle, held across exactly one sampling edge
   task automatic cmd(input logic [PART_W-1:0] p, input logic [BLK_W-1:0] b,
                      input logic [DATA_W-1:0] d);
      @(posedge sys_clk_i);
      #1;
      wr_en_o = 1'b1;
      wr_o = '{part: p, blk: b, data: d};
      @(posedge sys_clk_i);
      #1;
      wr_en_o = 1'b0;
      wr_o = ~wr_o;
   endtask
   // Both cycles go to one partition
   task automatic cmd2(input logic [PART_W-1:0] p, input logic [BLK_W-1:0] b,
                       input logic [DATA_W-1:0] c1, input logic [DATA_W-1:0] c2);
      cmd(p, b, c1);
      cmd(p, b, c2);
   endtask
   // Factory data only once the ready bit reads low
   task automatic ffp_word(input logic [PART_W-1:0] p, input logic [BLK_W-1:0] b,
      input logic [DATA_W-1:0] d, output logic ok);
      int n;
      n = 0;
      while (factory_write_ready_bit_i !== 1'b0 && n < 50) begin
         @(posedge sys_clk_i);
         #1;
         n++;
      end
      ok = (factory_write_ready_bit_i === 1'b0);
      if (ok) begin
         cmd(p, b, d);
      end
   endtask
endmodule
`default_nettype wire

// ### dv/flash_partition_command_fsm_bench.sv
`timescale 1ns/1ps
`default_nettype none
module flash_partition_command_fsm_bench;
   import fpcf_pkg::*;
   logic sys_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic op_done_i = 1'b0;
   logic ffp_word_busy_i = 1'b0;
   logic [PART_W-1:0] rd_part_i = '0;
   logic wr_en;
   fpcf_wr_t wr;
   fpcf_state_t state;
   fpcf_op_t op;
   fpcf_wr_t op_wr;
   fpcf_mode_t rd_mode;
   logic rd_undef, seq_err, lock_err, rdy_bit, ok;
   int bad_count = 0;
   int n_tests = 0;
   always #10 sys_clk_i = ~sys_clk_i;
   fpcf_cmd_fsm fpcf_cmd_fsm_i (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .wr_en_i(wr_en),
      .wr_i(wr), .op_done_i(op_done_i), .ffp_word_busy_i(ffp_word_busy_i),
      .rd_part_i(rd_part_i), .state_o(state), .op_o(op), .op_wr_o(op_wr), .rd_mode_o(rd_mode),
      .rd_undefined_o(rd_undef), .seq_err_o(seq_err), .lock_err_o(lock_err),
      .factory_write_ready_bit_o(rdy_bit));
   fpcf_host_model fpcf_host_model_i (.sys_clk_i(sys_clk_i),
      .factory_write_ready_bit_i(rdy_bit), .wr_en_o(wr_en), .wr_o(wr));
   task automatic fail(input string what, input logic [31:0] e, input logic [31:0] s);
      bad_count++;
      $display("[ERR] %s exp %0h seen %0h", what, e, s);
   endtask
   task automatic chk_st(input fpcf_state_t e);
      n_tests++;
      if (state !== e) fail("state_o", 32'(e), 32'(state));
   endtask
   task automatic chk_op(input fpcf_op_t e);
      n_tests++;
      if (op !== e) fail("op_o", 32'(e), 32'(op));
   endtask
   task automatic chk_bit(input string what, input logic e, input logic s);
      n_tests++;
      if (s !== e) fail(what, 32'(e), 32'(s));
   endtask
   task automatic chk_mode(input logic [PART_W-1:0] p, input fpcf_mode_t e);
      rd_part_i = p;
      repeat (2) @(posedge sys_clk_i);
      #1;
      n_tests++;
      if (rd_mode !== e) fail("rd_mode_o", 32'(e), 32'(rd_mode));
   endtask
   task automatic done_pulse();
      @(posedge sys_clk_i);
      #1;
      op_done_i = 1'b1;
      @(posedge sys_clk_i);
      #1;
      op_done_i = 1'b0;
   endtask
   task automatic t_reset();
      chk_st(ST_READY);
      chk_op(OP_NONE);
      chk_bit("seq_err_o", 1'b0, seq_err);
      chk_bit("lock_err_o", 1'b0, lock_err);
      chk_bit("ready_bit", 1'b1, rdy_bit);
      for (int p = 0; p < NPART; p++) chk_mode(p[PART_W-1:0], MODE_ARRAY);
   endtask
   task automatic t_modes();
      fpcf_host_model_i.cmd(2, 0, 16'h0090);
      chk_mode(2, MODE_ID);
      chk_mode(4, MODE_ARRAY);
      fpcf_host_model_i.cmd(4, 0, 16'h0070);
      repeat (5) @(posedge sys_clk_i);
      #1;
      chk_mode(4, MODE_STATUS);
      chk_mode(2, MODE_ID);
      fpcf_host_model_i.cmd(2, 0, 16'h0098);
      chk_mode(2, MODE_ID);
      fpcf_host_model_i.cmd(2, 0, 16'h00FF);
      chk_mode(2, MODE_ARRAY);
   endtask
   task automatic t_cross();
      fpcf_host_model_i.cmd(1, 0, 16'h0090);
      fpcf_host_model_i.cmd(1, 0, 16'h0040);
      chk_st(ST_PGM_SETUP);
      fpcf_host_model_i.cmd(3, 9, 16'h1234);
      chk_st(ST_PGM_BUSY);
      chk_op(OP_PGM);
      chk_bit("op_wr_part_is_3", 1'b1, op_wr.part === 3'h3);
      chk_mode(1, MODE_STATUS);
      chk_mode(3, MODE_STATUS);
      fpcf_host_model_i.cmd2(3, 0, 16'h0020, 16'h00D0);
      chk_st(ST_PGM_BUSY);
      chk_op(OP_NONE);
      fpcf_host_model_i.cmd(3, 0, 16'h00B0);
      chk_st(ST_PGM_SUSP);
      chk_op(OP_SUSPEND);
      fpcf_host_model_i.cmd(3, 0, 16'h0040);
      chk_st(ST_PGM_SUSP);
      chk_op(OP_NONE);
      fpcf_host_model_i.cmd(3, 0, 16'h00D0);
      chk_st(ST_PGM_BUSY);
      chk_op(OP_RESUME);
      fpcf_host_model_i.cmd(3, 0, 16'h00FF);
      chk_mode(3, MODE_ARRAY);
      chk_bit("rd_undefined_o", 1'b1, rd_undef);
      done_pulse();
      chk_st(ST_READY);
      chk_mode(3, MODE_ARRAY);
      chk_bit("rd_undefined_o", 1'b0, rd_undef);
   endtask
   task automatic t_suspend();
      logic [DATA_W-1:0] bad_setup [3] = '{16'h00C0, 16'h0030, 16'h0020};
      fpcf_host_model_i.cmd(0, 0, 16'h0077);
      chk_bit("seq_err_o", 1'b1, seq_err);
      fpcf_host_model_i.cmd2(0, 1, 16'h0020, 16'h00D0);
      chk_st(ST_ERS_BUSY);
      chk_op(OP_ERASE);
      fpcf_host_model_i.cmd(0, 1, 16'h0050);
      chk_bit("seq_err_o", 1'b1, seq_err);
      fpcf_host_model_i.cmd(0, 1, 16'h00B0);
      chk_st(ST_ERS_SUSP);
      chk_op(OP_SUSPEND);
      fpcf_host_model_i.cmd(0, 1, 16'h0050);
      chk_bit("seq_err_o", 1'b1, seq_err);
      for (int i = 0; i < 3; i++) begin
         fpcf_host_model_i.cmd(0, 1, bad_setup[i]);
         chk_st(ST_ERS_SUSP);
         fpcf_host_model_i.cmd(0, 1, 16'h0055);
         chk_st(ST_ERS_SUSP);
      end
      fpcf_host_model_i.cmd(0, 1, 16'h0060);
      chk_st(ST_LCK_SETUP_ES);
      fpcf_host_model_i.cmd(0, 1, 16'h0001);
      chk_op(OP_LOCK);
      chk_st(ST_ERS_SUSP);
      fpcf_host_model_i.cmd2(5, 2, 16'h0040, 16'hABCD);
      chk_st(ST_PES_BUSY);
      chk_op(OP_PGM);
      fpcf_host_model_i.cmd(5, 2, 16'h00B0);
      chk_st(ST_PES_SUSP);
      fpcf_host_model_i.cmd(5, 2, 16'h0060);
      chk_st(ST_PES_SUSP);
      fpcf_host_model_i.cmd(5, 2, 16'h0040);
      chk_st(ST_PES_SUSP);
      chk_op(OP_NONE);
      fpcf_host_model_i.cmd(5, 2, 16'h00D0);
      chk_st(ST_PES_BUSY);
      chk_op(OP_RESUME);
      done_pulse();
      chk_st(ST_ERS_SUSP);
      fpcf_host_model_i.cmd(0, 1, 16'h00D0);
      chk_st(ST_ERS_BUSY);
      done_pulse();
      chk_st(ST_READY);
      fpcf_host_model_i.cmd(0, 0, 16'h0050);
      chk_op(OP_CLR_STAT);
      chk_bit("seq_err_o", 1'b0, seq_err);
   endtask
   task automatic t_lock();
      logic [DATA_W-1:0] conf [4] = '{16'h0001, 16'h00D0, 16'h002F, 16'h0003};
      fpcf_op_t ops [4] = '{OP_LOCK, OP_UNLOCK, OP_LOCKDN, OP_CFG};
      for (int i = 0; i < 4; i++) begin
         fpcf_host_model_i.cmd(6, 3, 16'h0060);
         chk_st(ST_LCK_SETUP);
         fpcf_host_model_i.cmd(6, 3, conf[i]);
         chk_op(ops[i]);
         chk_st(ST_READY);
      end
      fpcf_host_model_i.cmd(6, 3, 16'h0060);
      fpcf_host_model_i.cmd(6, 3, 16'h0077);
      chk_bit("lock_err_o", 1'b1, lock_err);
      chk_op(OP_NONE);
      chk_st(ST_READY);
      fpcf_host_model_i.cmd(6, 3, 16'h0050);
      chk_op(OP_CLR_STAT);
      chk_bit("lock_err_o", 1'b0, lock_err);
   endtask
   task automatic t_ffp();
      fpcf_host_model_i.cmd2(7, 5, 16'h0030, 16'h00D0);
      chk_st(ST_FFP_BUSY);
      ffp_word_busy_i = 1'b1;
      repeat (2) @(posedge sys_clk_i);
      #1;
      chk_bit("ready_bit", 1'b1, rdy_bit);
      ffp_word_busy_i = 1'b0;
      fpcf_host_model_i.ffp_word(7, 5, 16'h00FF, ok);
      chk_bit("ffp_write_ok", 1'b1, ok);
      chk_st(ST_FFP_BUSY);
      chk_op(OP_FFP_WORD);
      fpcf_host_model_i.ffp_word(7, 6, 16'h0000, ok);
      chk_st(ST_FFP_VERIFY);
      chk_bit("ready_bit", 1'b1, rdy_bit);
      fpcf_host_model_i.cmd(7, 5, 16'h0070);
      chk_st(ST_FFP_VERIFY);
      fpcf_host_model_i.cmd(7, 6, 16'h0000);
      chk_st(ST_READY);
   endtask
   task automatic end_sim();
      if (bad_count == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge sys_clk_i);
      #1;
      reset_n_i = 1'b1;
      t_reset();
      t_modes();
      t_cross();
      t_suspend();
      t_lock();
      t_ffp();
      end_sim();
   end
   initial begin
      #100000;
      bad_count++;
      end_sim();
   end
endmodule
`default_nettype wire
